/* File: gtm_far_model.sv */
// Far-side model: drives trigger, cascade and capture source levels.
// Assumes the bench sets requested levels; slow adds one cycle of delay.
`timescale 1ns/1ns
module gtm_far_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Requested levels and answer speed
   input  wire logic       slow,
   input  wire logic [8:0] req,
   // Levels seen by the timer
   output logic [8:0]      lvl
);
   logic [8:0] stage_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         stage_reg <= 9'h000;
         lvl       <= 9'h000;
      end
      else
      begin
         stage_reg <= req;
         lvl       <= slow ? stage_reg : req;
      end
   end
endmodule

/* File: gtm_general_timer.sv */
// General timer slice: counter with timer, counter, trigger-start and gated
// modes, per-channel capture and compare/PWM outputs, register port.
// Assumes external pins are asynchronous; cascade and on-chip sources share clk.
`timescale 1ns/1ns
module gtm_general_timer #(
   parameter int CNT_W = 16,
   parameter int N_CH  = 4,
   parameter int PRS_W = 3
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // Register port
   input  wire gtm_pkg::gtm_bus_req_t bus,
   output logic [31:0]               rdata,
   // Trigger and gate sources
   input  wire logic                 external_trigger_input,
   input  wire logic                 cascade_input,
   // Capture sources on chip
   input  wire logic [2:0]           uart_rxd,
   input  wire logic                 voltage_comparator_one,
   input  wire logic                 voltage_comparator_two,
   input  wire logic                 low_voltage_detector,
   // Channel pins
   input  wire logic [N_CH-1:0]      channel_pin_in,
   output logic [N_CH-1:0]           channel_pin_out,
   output logic [N_CH-1:0]           channel_pin_oe,
   // Interrupt request
   output logic                      irq
);
   import gtm_pkg::*;

   localparam int DIV_W = (1 << PRS_W) - 1;
   localparam int N_ST  = GTM_ST_CC_POS + N_CH;

   generate
      if (CNT_W < 2 || CNT_W > 32 || N_CH < 1 || N_CH > 8 || PRS_W < 1 || PRS_W > 4)
      begin : g_bad_params
         $error("gtm_general_timer: unsupported parameter values");
      end
   endgenerate

   typedef struct packed {
      logic                       en;
      gtm_mode_t                  mode;
      logic                       trigger_source_signal;
      logic                       trigger_polarity;
      logic [PRS_W-1:0]           prescale_coefficient;
      logic [CNT_W-1:0]           reload;
      logic [CNT_W-1:0]           cnt;
      logic [N_CH-1:0][3:0]       channel_compare_mode;
      logic [N_CH-1:0][2:0]       capsel;
      logic [N_CH-1:0][CNT_W-1:0] ccr;
      logic [N_ST-1:0]            st;
      logic [N_ST-1:0]            ien;
      logic [N_CH-1:0]            src_prev;
      logic [N_CH-1:0]            eq_prev;
      logic [N_CH-1:0]            ch_out;
      logic                       itr_prev;
      logic [DIV_W-1:0]           div;
      logic [31:0]                rdata;
   } gtm_state_t;

   gtm_state_t r;
   gtm_state_t n;

   logic             etr_lvl;
   logic             etr_rise;
   logic             etr_fall;
   logic [N_CH-1:0]  pin_lvl;
   logic             trig_edge;
   logic             gate_act;
   logic             run;
   logic             pre_in;
   logic             tick;
   logic             wr_cnt;
   logic [DIV_W-1:0] mask;
   logic [N_CH-1:0]  cap_evt;
   logic [N_CH-1:0]  match_evt;

   function automatic logic [GTM_ADDR_W-1:0] ccr_addr(input int idx);
      ccr_addr = GTM_ADDR_W'(int'(GTM_OFS_CCR0) + idx * GTM_CCR_STRIDE);
   endfunction

   // Pin conditioning
   gtm_input_sync u_etr_sync (
      .clk    (clk),
      .srst   (srst),
      .pin_in (external_trigger_input),
      .level  (etr_lvl),
      .rise   (etr_rise),
      .fall   (etr_fall)
   );

   generate
      for (genvar g = 0; g < N_CH; g++)
      begin : g_pin
         gtm_input_sync u_ch_sync (
            .clk    (clk),
            .srst   (srst),
            .pin_in (channel_pin_in[g]),
            .level  (pin_lvl[g]),
            .rise   (),
            .fall   ()
         );
         assign channel_pin_oe[g] = r.channel_compare_mode[g][GTM_CCM_OUT_POS];
      end
   endgenerate

   // Trigger source and edge choice
   assign trig_edge = (r.trigger_source_signal == GTM_TRS_CASCADE) ? (cascade_input && !r.itr_prev)
                                                 : (r.trigger_polarity ? etr_fall : etr_rise);
   // Gate level with polarity
   assign gate_act  = etr_lvl ^ r.trigger_polarity;
   // Count enable per mode
   assign run       = r.en && (r.mode != GTM_MODE_GATED || gate_act);
   // Counter mode feeds trigger edges to the prescaler, others the clock
   assign pre_in    = (r.mode == GTM_MODE_COUNTER) ? trig_edge : 1'b1;
   assign mask      = ~({DIV_W{1'b1}} << r.prescale_coefficient);
   assign tick      = run && pre_in && ((r.div & mask) == mask);
   assign wr_cnt    = bus.wr && (bus.addr == GTM_OFS_COUNT);

   always_comb
   begin
      logic [7:0]      srcs;
      logic            src;
      logic            eq;
      logic [N_ST-1:0] set_v;
      logic [N_ST-1:0] clr_v;
      logic [31:0]     rd_v;
      srcs      = '0;
      src       = 1'b0;
      eq        = 1'b0;
      set_v     = '0;
      clr_v     = '0;
      rd_v      = '0;
      n         = r;
      cap_evt   = '0;
      match_evt = '0;

      // Software writes
      if (bus.wr)
      begin
         case (bus.addr)
            GTM_OFS_CTRL0:
            begin
               n.en   = bus.wdata[GTM_CR0_EN_POS];
               n.mode = gtm_mode_t'(bus.wdata[GTM_CR0_MODE_POS +: 2]);
               n.trigger_source_signal  = bus.wdata[GTM_CR0_TRS_POS];
               n.trigger_polarity  = bus.wdata[GTM_CR0_POL_POS];
               n.prescale_coefficient  = bus.wdata[GTM_CR0_PRS_POS +: PRS_W];
               // Software resume after a pause counts as a fresh trigger
               if (r.mode == GTM_MODE_TRIGGER && !r.en && bus.wdata[GTM_CR0_EN_POS] &&
                   bus.wdata[GTM_CR0_MODE_POS +: 2] == GTM_MODE_TRIGGER)
                  set_v[GTM_ST_TRIG_POS] = 1'b1;
            end
            GTM_OFS_RELOAD: n.reload = bus.wdata[CNT_W-1:0];
            GTM_OFS_COUNT:  n.cnt    = bus.wdata[CNT_W-1:0];
            GTM_OFS_CHMODE: n.channel_compare_mode   = bus.wdata[4*N_CH-1:0];
            GTM_OFS_CAPSEL: n.capsel = bus.wdata[3*N_CH-1:0];
            GTM_OFS_IEN:    n.ien    = bus.wdata[N_ST-1:0];
            GTM_OFS_ICLR:   clr_v    = ~bus.wdata[N_ST-1:0];
            default:        ;
         endcase
         for (int i = 0; i < N_CH; i++)
         begin
            if (bus.addr == ccr_addr(i))
               n.ccr[i] = bus.wdata[CNT_W-1:0];
         end
      end

      // Prescaler and counter
      if (run && pre_in)
         n.div = r.div + 1'b1;
      if (tick && !wr_cnt)
      begin
         if (r.cnt == r.reload)
         begin
            n.cnt                = '0;
            set_v[GTM_ST_OV_POS] = 1'b1;
         end
         else
            n.cnt = r.cnt + 1'b1;
      end

      // Trigger start: hardware enable wins over a software clear
      n.itr_prev = cascade_input;
      if (r.mode == GTM_MODE_TRIGGER && trig_edge)
      begin
         n.en                   = 1'b1;
         set_v[GTM_ST_TRIG_POS] = 1'b1;
      end

      // Channels
      for (int i = 0; i < N_CH; i++)
      begin
         srcs          = {1'b0, low_voltage_detector, voltage_comparator_two,
                          voltage_comparator_one, uart_rxd, pin_lvl[i]};
         src           = srcs[r.capsel[i]];
         n.src_prev[i] = src;
         eq            = (r.cnt == r.ccr[i]);
         n.eq_prev[i]  = eq;
         if (!r.channel_compare_mode[i][GTM_CCM_OUT_POS])
         begin
            cap_evt[i] = (src && !r.src_prev[i] && r.channel_compare_mode[i][GTM_CCM_RISE_POS]) ||
                         (!src && r.src_prev[i] && r.channel_compare_mode[i][GTM_CCM_FALL_POS]);
            if (cap_evt[i])
            begin
               n.ccr[i]                   = r.cnt;
               set_v[GTM_ST_CC_POS + i]   = 1'b1;
            end
         end
         else
         begin
            // Flag only on entering equality, so a paused counter flags once
            match_evt[i] = eq && !r.eq_prev[i];
            if (match_evt[i])
               set_v[GTM_ST_CC_POS + i] = 1'b1;
            case (r.channel_compare_mode[i])
               GTM_CCM_FORCE_LO: n.ch_out[i] = 1'b0;
               GTM_CCM_FORCE_HI: n.ch_out[i] = 1'b1;
               GTM_CCM_MATCH_LO: if (match_evt[i]) n.ch_out[i] = 1'b0;
               GTM_CCM_MATCH_HI: if (match_evt[i]) n.ch_out[i] = 1'b1;
               GTM_CCM_PWM_POS:  n.ch_out[i] = (r.cnt >= r.ccr[i]);
               GTM_CCM_PWM_NEG:  n.ch_out[i] = (r.cnt < r.ccr[i]);
               default:          ;
            endcase
         end
      end

      // Sticky flags, set beats clear
      n.st = (r.st & ~clr_v) | set_v;

      // Read data, valid only in the cycle after the strobe
      case (bus.addr)
         GTM_OFS_CTRL0:
         begin
            rd_v[GTM_CR0_EN_POS]             = r.en;
            rd_v[GTM_CR0_MODE_POS +: 2]      = r.mode;
            rd_v[GTM_CR0_TRS_POS]            = r.trigger_source_signal;
            rd_v[GTM_CR0_POL_POS]            = r.trigger_polarity;
            rd_v[GTM_CR0_PRS_POS +: PRS_W]   = r.prescale_coefficient;
         end
         GTM_OFS_RELOAD: rd_v[CNT_W-1:0]  = r.reload;
         GTM_OFS_COUNT:  rd_v[CNT_W-1:0]  = r.cnt;
         GTM_OFS_CHMODE: rd_v[4*N_CH-1:0] = r.channel_compare_mode;
         GTM_OFS_CAPSEL: rd_v[3*N_CH-1:0] = r.capsel;
         GTM_OFS_STATUS: rd_v[N_ST-1:0]   = r.st;
         GTM_OFS_IEN:    rd_v[N_ST-1:0]   = r.ien;
         default:        ;
      endcase
      for (int i = 0; i < N_CH; i++)
      begin
         if (bus.addr == ccr_addr(i))
            rd_v[CNT_W-1:0] = r.ccr[i];
      end
      n.rdata = bus.rd ? rd_v : 32'h00000000;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         r        <= '0;
         r.reload <= GTM_RST_RELOAD[CNT_W-1:0];
      end
      else
         r <= n;
   end

   assign rdata           = r.rdata;
   assign channel_pin_out = r.ch_out;
   assign irq             = |(r.st & r.ien);

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_CNT_WRAP: assert property (tick && !wr_cnt && r.cnt == r.reload |=> r.cnt == '0 && r.st[GTM_ST_OV_POS])
      else $error("Counter did not restart from zero at reload");
   AST_CNT_STEP: assert property (tick && !wr_cnt && r.cnt != r.reload |=> r.cnt == $past(r.cnt) + 1'b1)
      else $error("Counter did not step by one on a tick");
   AST_CNT_SRC: assert property (r.mode == GTM_MODE_COUNTER && !trig_edge && !wr_cnt |=> $stable(r.cnt))
      else $error("Counter mode moved without a trigger edge");
   AST_GATE_HALT: assert property (r.mode == GTM_MODE_GATED && !gate_act && !wr_cnt |=> $stable(r.cnt))
      else $error("Gated counter moved with inactive gate");
   AST_GATE_RUN: assert property (r.mode == GTM_MODE_GATED && r.en && gate_act && r.prescale_coefficient == '0 |-> tick)
      else $error("Gated counter missed a tick with active gate");
   AST_TRIG_START: assert property (r.mode == GTM_MODE_TRIGGER && trig_edge |=> r.en && r.st[GTM_ST_TRIG_POS])
      else $error("Trigger edge did not enable and flag");
   AST_PRS_DIV: assert property (tick && r.prescale_coefficient != '0 && r.mode != GTM_MODE_COUNTER |=> !tick)
      else $error("Prescaled tick came on consecutive cycles");
   AST_PRS_PASS: assert property (r.mode == GTM_MODE_TIMER && r.en && r.prescale_coefficient == '0 |-> tick)
      else $error("Undivided clock missed a tick");

   generate
      for (genvar c = 0; c < N_CH; c++)
      begin : g_chk
         AST_CAPTURE: assert property (cap_evt[c] |=> r.ccr[c] == $past(r.cnt) && r.st[GTM_ST_CC_POS + c])
            else $error("Capture did not store the count and flag");
         AST_STICKY: assert property (r.st[GTM_ST_CC_POS + c] &&
                                      !(bus.wr && bus.addr == GTM_OFS_ICLR && !bus.wdata[GTM_ST_CC_POS + c])
                                      |=> r.st[GTM_ST_CC_POS + c])
            else $error("Channel flag dropped without a clear");
         AST_IRQ: assert property (cap_evt[c] && r.ien[GTM_ST_CC_POS + c] &&
                                   !(bus.wr && bus.addr == GTM_OFS_IEN) |=> irq)
            else $error("Enabled capture raised no interrupt");
         AST_MATCH_HI: assert property (r.channel_compare_mode[c] == GTM_CCM_MATCH_HI && match_evt[c]
                                        |=> r.ch_out[c] && r.st[GTM_ST_CC_POS + c])
            else $error("Set-on-match did not drive high and flag");
         AST_FORCE_LO: assert property (r.channel_compare_mode[c] == GTM_CCM_FORCE_LO |=> !r.ch_out[c])
            else $error("Forced low output is high");
         AST_PWM_POS: assert property (r.channel_compare_mode[c] == GTM_CCM_PWM_POS
                                       |=> r.ch_out[c] == ($past(r.cnt) >= $past(r.ccr[c])))
            else $error("PWM output disagrees with compare");
         AST_PWM_NEG: assert property (r.channel_compare_mode[c] == GTM_CCM_PWM_NEG
                                       |=> r.ch_out[c] == ($past(r.cnt) < $past(r.ccr[c])))
            else $error("Reverse PWM output disagrees with compare");
         AST_FORCE_HI: assert property (r.channel_compare_mode[c] == GTM_CCM_FORCE_HI |=> r.ch_out[c])
            else $error("Forced high output is low");
         AST_MATCH_LO: assert property (r.channel_compare_mode[c] == GTM_CCM_MATCH_LO && match_evt[c]
                                        |=> !r.ch_out[c] && r.st[GTM_ST_CC_POS + c])
            else $error("Clear-on-match did not drive low and flag");
      end
   endgenerate

endmodule

/* File: gtm_input_sync.sv */
// Pin conditioner: three-stage synchroniser with a two-sample agreement
// filter and registered edge pulses. Assumes an input from outside clk.
`timescale 1ns/1ns
module gtm_input_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Raw pin
   input  wire logic pin_in,
   // Conditioned level and one-cycle edge pulses
   output logic      level,
   output logic      rise,
   output logic      fall
);
   import gtm_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rise;
      logic fall;
   } gtm_sync_state_t;

   gtm_sync_state_t r;
   gtm_sync_state_t n;

   always_comb
   begin
      n      = r;
      n.s1   = pin_in;
      n.s2   = r.s1;
      n.s3   = r.s2;
      n.rise = 1'b0;
      n.fall = 1'b0;
      // A change counts once the second and third stages agree
      if (r.s2 == r.s3 && r.s2 != r.lvl)
      begin
         n.lvl  = r.s2;
         n.rise = r.s2;
         n.fall = !r.s2;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         r <= '0;
      else
         r <= n;
   end

   assign level = r.lvl;
   assign rise  = r.rise;
   assign fall  = r.fall;

endmodule

/* File: gtm_pkg.sv */
// Shared constants and types for the general timer slice.
// Assumes one clock domain; the register port is a plain strobe port.
package gtm_pkg;

   localparam int GTM_ADDR_W = 8;

   // Register port request from the bus master
   typedef struct packed {
      logic [GTM_ADDR_W-1:0] addr;
      logic [31:0]           wdata;
      logic                  wr;
      logic                  rd;
   } gtm_bus_req_t;

   // Register byte offsets
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_CTRL0  = 8'h00;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_RELOAD = 8'h04;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_COUNT  = 8'h08;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_CHMODE = 8'h0c;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_CAPSEL = 8'h10;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_STATUS = 8'h14;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_IEN    = 8'h18;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_ICLR   = 8'h1c;
   localparam logic [GTM_ADDR_W-1:0] GTM_OFS_CCR0   = 8'h20;
   localparam int                    GTM_CCR_STRIDE = 4;

   // Field positions in timer_control_zero
   localparam int GTM_CR0_EN_POS   = 0;
   localparam int GTM_CR0_MODE_POS = 1;
   localparam int GTM_CR0_TRS_POS  = 3;
   localparam int GTM_CR0_POL_POS  = 4;
   localparam int GTM_CR0_PRS_POS  = 5;

   // Field positions in interrupt_status, interrupt_enable_reg, interrupt_clear_reg
   localparam int GTM_ST_OV_POS   = 0;
   localparam int GTM_ST_TRIG_POS = 1;
   localparam int GTM_ST_CC_POS   = 2;

   // Operating modes
   typedef enum logic [1:0] {
      GTM_MODE_TIMER   = 2'h0,
      GTM_MODE_COUNTER = 2'h1,
      GTM_MODE_TRIGGER = 2'h2,
      GTM_MODE_GATED   = 2'h3
   } gtm_mode_t;

   // Trigger source select
   localparam logic GTM_TRS_EXT     = 1'h0;
   localparam logic GTM_TRS_CASCADE = 1'h1;

   // Channel compare mode codes; a clear top bit means capture
   localparam int         GTM_CCM_OUT_POS  = 3;
   localparam int         GTM_CCM_RISE_POS = 0;
   localparam int         GTM_CCM_FALL_POS = 1;
   localparam logic [3:0] GTM_CCM_FORCE_LO = 4'h8;
   localparam logic [3:0] GTM_CCM_FORCE_HI = 4'h9;
   localparam logic [3:0] GTM_CCM_MATCH_LO = 4'ha;
   localparam logic [3:0] GTM_CCM_MATCH_HI = 4'hb;
   localparam logic [3:0] GTM_CCM_PWM_POS  = 4'he;
   localparam logic [3:0] GTM_CCM_PWM_NEG  = 4'hf;

   // Capture source codes
   localparam logic [2:0] GTM_CAP_PIN   = 3'h0;
   localparam logic [2:0] GTM_CAP_UART1 = 3'h1;
   localparam logic [2:0] GTM_CAP_VC1   = 3'h4;
   localparam logic [2:0] GTM_CAP_VC2   = 3'h5;
   localparam logic [2:0] GTM_CAP_LVD   = 3'h6;

   // Values after reset
   localparam logic [31:0] GTM_RST_RELOAD = 32'h0000ffff;

endpackage

/* File: tb.sv */
// Self-checking bench for the general timer slice.
// Assumes the far-side model drives every trigger and capture source except the pins of channels 1 to 3, which are tied low.
`timescale 1ns/1ns
module tb;
   import gtm_pkg::*;
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   gtm_bus_req_t bus = '0;
   logic [31:0]  rdata;
   logic         slow = 1'b0;
   logic [8:0]   req = 9'h000;
   logic [8:0]   lvl;
   logic [3:0]   pin_out;
   logic [3:0]   pin_oe;
   logic         irq;
   int           bad_count = 0;
   int           tests_run = 0;
   logic [31:0]  val;
   logic [31:0]  prev;

   always #4 clk = ~clk;

   // Bit 0 external trigger, bit 1 cascade, bits 8:2 capture sources 0..6
   gtm_far_model gtm_far_model_inst (.clk(clk), .srst(srst), .slow(slow), .req(req), .lvl(lvl));
   gtm_general_timer gtm_general_timer_inst (
      .clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
      .external_trigger_input(lvl[0]), .cascade_input(lvl[1]), .uart_rxd(lvl[5:3]),
      .voltage_comparator_one(lvl[6]), .voltage_comparator_two(lvl[7]), .low_voltage_detector(lvl[8]),
      .channel_pin_in({3'h0, lvl[2]}), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq(irq));

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d & mask, exp);
   endtask

   task automatic setreq(input int b, input logic v);
      @(posedge clk);
      req[b] <= v;
      repeat (10) @(posedge clk);
   endtask

   task automatic pulse(input int b, input int n);
      repeat (n)
      begin
         @(posedge clk);
         req[b] <= 1'b1;
         repeat (6) @(posedge clk);
         req[b] <= 1'b0;
         repeat (5) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask

   // Set a compare mode and counter value, then look at channel 0
   task automatic cmp(input logic [3:0] m, input logic [31:0] c, input logic o);
      wr(GTM_OFS_CHMODE, {28'h0, m});
      wr(GTM_OFS_COUNT, c);
      repeat (4) @(posedge clk);
      #1 check({30'h0, pin_oe[0], pin_out[0]}, {30'h0, 1'b1, o});
   endtask

   function automatic logic [31:0] cr(input logic en, input logic [1:0] m, input logic trigger_source_signal, input logic trigger_polarity,
                                      input logic [2:0] prescale_coefficient);
      return {24'h0, prescale_coefficient, trigger_polarity, trigger_source_signal, m, en};
   endfunction

   initial
   begin
      repeat (60000) @(posedge clk);
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      print_verdict();
   end

   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk(GTM_OFS_RELOAD, '1, 32'h0000ffff);
      rd_chk(8'hfc, '1, 32'h0);
      wr(GTM_OFS_CTRL0, cr(1, 1, 1, 0, 0));
      pulse(1, 5);
      rd_chk(GTM_OFS_COUNT, '1, 32'h5);
      wr(GTM_OFS_COUNT, 32'h0);
      wr(GTM_OFS_CTRL0, cr(1, 1, 1, 0, 1));
      pulse(1, 4);
      rd_chk(GTM_OFS_COUNT, '1, 32'h2);
      // Falling edges only must count on the external input
      setreq(0, 1);
      wr(GTM_OFS_COUNT, 32'h0);
      wr(GTM_OFS_CTRL0, cr(1, 1, 0, 1, 0));
      setreq(0, 0);
      rd_chk(GTM_OFS_COUNT, '1, 32'h1);
      setreq(0, 1);
      rd_chk(GTM_OFS_COUNT, '1, 32'h1);
      wr(GTM_OFS_RELOAD, 32'h2);
      wr(GTM_OFS_COUNT, 32'h0);
      wr(GTM_OFS_CTRL0, cr(1, 1, 1, 0, 0));
      pulse(1, 3);
      rd_chk(GTM_OFS_COUNT, '1, 32'h0);
      rd_chk(GTM_OFS_STATUS, 32'h1, 32'h1);
      wr(GTM_OFS_ICLR, 32'hfffffffe);
      rd_chk(GTM_OFS_STATUS, 32'h1, 32'h0);
      wr(GTM_OFS_RELOAD, 32'h0000ffff);
      wr(GTM_OFS_COUNT, 32'h0);
      wr(GTM_OFS_CTRL0, cr(0, 2, 1, 0, 0));
      rd_chk(GTM_OFS_COUNT, '1, 32'h0);
      pulse(1, 1);
      rd_chk(GTM_OFS_CTRL0, 32'h1, 32'h1);
      rd_chk(GTM_OFS_STATUS, 32'h2, 32'h2);
      wr(GTM_OFS_CTRL0, cr(0, 2, 1, 0, 0));
      rd(GTM_OFS_COUNT, prev);
      rd_chk(GTM_OFS_COUNT, '1, prev);
      wr(GTM_OFS_ICLR, 32'hfffffffd);
      pulse(1, 1);
      rd_chk(GTM_OFS_STATUS, 32'h2, 32'h2);
      rd(GTM_OFS_COUNT, val);
      check(val > prev, 32'h1);
      wr(GTM_OFS_CTRL0, cr(0, 2, 1, 0, 0));
      wr(GTM_OFS_ICLR, 32'hfffffffd);
      wr(GTM_OFS_CTRL0, cr(1, 2, 1, 0, 0));
      rd_chk(GTM_OFS_STATUS, 32'h2, 32'h2);
      wr(GTM_OFS_CTRL0, cr(0, 3, 0, 0, 0));
      setreq(0, 0);
      wr(GTM_OFS_COUNT, 32'h0);
      wr(GTM_OFS_CTRL0, cr(1, 3, 0, 0, 0));
      rd_chk(GTM_OFS_COUNT, '1, 32'h0);
      setreq(0, 1);
      setreq(0, 0);
      rd(GTM_OFS_COUNT, prev);
      check(prev != 32'h0, 32'h1);
      rd_chk(GTM_OFS_COUNT, '1, prev);
      wr(GTM_OFS_CTRL0, cr(1, 3, 0, 1, 0));
      setreq(0, 0);
      rd(GTM_OFS_COUNT, val);
      check(val > prev + 32'h4, 32'h1);
      // Timer mode: 20 enabled cycles give 20 >> prescale ticks
      for (int p = 0; p < 3; p++)
      begin
         wr(GTM_OFS_CTRL0, 32'h0);
         wr(GTM_OFS_COUNT, 32'h0);
         wr(GTM_OFS_CTRL0, cr(1, 0, 0, 0, 3'(p)));
         repeat (18) @(posedge clk);
         wr(GTM_OFS_CTRL0, cr(0, 0, 0, 0, 3'(p)));
         rd_chk(GTM_OFS_COUNT, '1, 32'h14 >> p);
      end
      // Capture from every source into channel 0 with the counter frozen
      wr(GTM_OFS_CTRL0, 32'h0);
      wr(GTM_OFS_COUNT, 32'h1234);
      wr(GTM_OFS_IEN, 32'h4);
      wr(GTM_OFS_CHMODE, 32'h1);
      for (int s = 0; s < 7; s++)
      begin
         wr(GTM_OFS_CAPSEL, 32'(s));
         slow <= s[0];
         wr(GTM_OFS_CCR0, 32'h0);
         setreq(s + 2, 1);
         rd_chk(GTM_OFS_CCR0, '1, 32'h1234);
         rd_chk(GTM_OFS_STATUS, 32'h4, 32'h4);
         check({31'h0, irq}, 32'h1);
         wr(GTM_OFS_ICLR, 32'hfffffffb);
         rd_chk(GTM_OFS_STATUS, 32'h4, 32'h0);
         check({31'h0, irq}, 32'h0);
         setreq(s + 2, 0);
      end
      wr(GTM_OFS_CCR0, 32'h40);
      cmp(4'h9, 32'h10, 1'b1);
      cmp(4'h8, 32'h10, 1'b0);
      wr(GTM_OFS_ICLR, 32'hfffffffb);
      cmp(4'hb, 32'h40, 1'b1);
      rd_chk(GTM_OFS_STATUS, 32'h4, 32'h4);
      wr(GTM_OFS_COUNT, 32'h10);
      cmp(4'ha, 32'h40, 1'b0);
      cmp(4'he, 32'h3f, 1'b0);
      cmp(4'he, 32'h40, 1'b1);
      cmp(4'hf, 32'h40, 1'b0);
      cmp(4'hf, 32'h3f, 1'b1);
      print_verdict();
   end
endmodule
